// ### core/lqm_monitor.sv
// Purpose: Link quality threshold monitor with Avalon-MM registers
// Assumes: Parameter samples arrive synchronous to clock; link inputs are pins
// Notes: Values and thresholds are signed two's complement
//
// Overview of operation
// - Monitoring runs only while control bit 15 is set; resets disabled.
// - Enable is effective only while a valid 100 Mb link exists.
// - Maximum high or minimum low threshold is never violated.
// - Violation asserts interrupt when its interrupt enable is set.
// - Reading monitor control clears all warning flags and re-arms interrupt.
// - Bit 14 plus frequency control violation restarts receiver DSP.
// - Bit 13 plus frequency offset violation restarts receiver DSP.
// - Bit 12 plus baseline wander violation restarts receiver DSP.
// - Bit 11 plus digital gain violation restarts receiver DSP.
// - Bit 10 plus equalizer coefficient violation restarts receiver DSP.
// - Triggered restart with signal detect option 0 also drops link status.
// - Frequency control high flag bit 9, low bit 8, clear on read.
// - Frequency offset high flag bit 7, low bit 6, clear on read.
// - Baseline wander high flag bit 5, low bit 4, clear on read.
// - Digital gain high flag bit 3, low bit 2, clear on read.
// - Equalizer coefficient high flag bit 1, low bit 0, clear on read.
// - Threshold write trigger bit 12 loads selected threshold; reads as 0.
`timescale 1ns/100ps
module lqm_monitor
	import lqm_pkg::*;
(
	input wire logic clock, // Core clock, 40 MHz
	input wire logic rst, // Async reset, active high
	input wire logic [4:0] avs_address, // Word address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte lanes
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall
	input wire lqm_sample_s sample, // Adapted parameter sample
	input wire logic link_up_100, // Valid 100 Mb link, async pin
	output logic dsp_restart, // Reset DSP and restart adaption
	output logic link_drop, // Force link status down
	output logic irq // Level interrupt
);
	// Sampled parameter index to flag bit pair: coeff=0, gain=1, wander=2, offset=3, freq ctrl=4
	logic [15:0] ctrl_reg;
	logic [15:0] thr_acc_reg;
	logic [1:0] irq_stat_reg;
	logic [1:0] irq_mask_reg;
	logic sd_opt_reg;
	logic armed_reg;
	logic [LQM_NPARAM-1:0][LQM_VALW-1:0] thr_hi_reg;
	logic [LQM_NPARAM-1:0][LQM_VALW-1:0] thr_lo_reg;
	logic [1:0] link_sync_reg;
	lqm_bus_e bus_reg;
	logic [31:0] rdata_reg;
	logic [2:0] rst_cnt_reg;
	logic drop_reg;

	// Link pin resynchronised before use
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			link_sync_reg <= 2'h0;
		end else begin
			link_sync_reg <= {link_sync_reg[0], link_up_100};
		end
	end

	wire link_ok = link_sync_reg[1];
	wire mon_active = ctrl_reg[LQM_BIT_ENABLE] && link_ok;

	// Per-parameter comparison; extreme thresholds disable their check
	logic [LQM_NPARAM-1:0] hi_viol;
	logic [LQM_NPARAM-1:0] lo_viol;
	genvar g;
	generate
		for (g = 0; g < LQM_NPARAM; g++) begin : g_cmp
			assign hi_viol[g] = mon_active && sample.valid
				&& (thr_hi_reg[g] != LQM_THR_MAX)
				&& ($signed(sample.value[g]) > $signed(thr_hi_reg[g]));
			assign lo_viol[g] = mon_active && sample.valid
				&& (thr_lo_reg[g] != LQM_THR_MIN)
				&& ($signed(sample.value[g]) < $signed(thr_lo_reg[g]));
		end
	endgenerate

	// Flags interleave high/low per parameter, FC at top
	logic [9:0] warn_set;
	generate
		for (g = 0; g < LQM_NPARAM; g++) begin : g_flag
			assign warn_set[2*g+1] = hi_viol[g];
			assign warn_set[2*g] = lo_viol[g];
		end
	endgenerate

	// Restart enables sit at bits 14..10 in FC..C1 order
	wire [4:0] rst_en = ctrl_reg[LQM_BIT_RST_FC:LQM_BIT_RST_C1];
	wire [4:0] par_viol = hi_viol | lo_viol;
	wire restart_hit = |(rst_en & par_viol);
	wire any_viol = |par_viol;

	// Bus decode; a read acts at the first edge of its access, so the flags it
	// returns are exactly the ones it clears, while writes land at the accept edge
	wire bus_req = (avs_read || avs_write) && (bus_reg == LQM_BUS_IDLE);
	wire bus_acc = (avs_read || avs_write) && (bus_reg == LQM_BUS_ACK);
	wire sel_ctrl = (avs_address == LQM_IDX_MON_CTRL);
	wire sel_thr = (avs_address == LQM_IDX_THR_ACC);
	wire sel_stat = (avs_address == LQM_IDX_IRQ_STAT);
	wire sel_mask = (avs_address == LQM_IDX_IRQ_MASK);
	wire sel_pcs = (avs_address == LQM_IDX_PCS_CFG);
	wire sel_rx = (avs_address == LQM_IDX_RX_STAT);
	wire wr_lo = bus_acc && avs_write && avs_byteenable[0];
	wire wr_hi = bus_acc && avs_write && avs_byteenable[1];
	wire wr_data = bus_acc && avs_write && (&avs_byteenable[3:2]);
	wire rd_ctrl = bus_req && avs_read && sel_ctrl;
	wire [2:0] psel = thr_acc_reg[LQM_POS_PSEL +: 3];
	wire hl_sel = thr_acc_reg[LQM_BIT_HLSEL];
	wire [15:0] thr_wdata = avs_writedata[31:16]; // Threshold value rides in the upper half
	wire [9:0] warn_flags = ctrl_reg[LQM_BIT_FC_HI:0];

	// Read mux; unmapped words read as zero
	logic [31:0] rd_mux;
	assign rd_mux = sel_ctrl ? {16'h0000, ctrl_reg} :
		sel_thr ? {16'h0000, thr_acc_reg} :
		sel_stat ? {30'h0000_0000, irq_stat_reg} :
		sel_mask ? {30'h0000_0000, irq_mask_reg} :
		sel_pcs ? {23'h00_0000, sd_opt_reg, 8'h00} :
		sel_rx ? {28'h000_0000, rst_cnt_reg != 3'h0, drop_reg, link_ok, mon_active} :
		32'h0000_0000;

	// One wait cycle then answer; readdata registered
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bus_reg <= LQM_BUS_IDLE;
			rdata_reg <= 32'h0000_0000;
		end else begin
			case (bus_reg)
				LQM_BUS_IDLE: begin
					if (avs_read || avs_write) begin
						bus_reg <= LQM_BUS_ACK;
						rdata_reg <= rd_mux;
					end
				end
				default: begin
					bus_reg <= LQM_BUS_IDLE;
				end
			endcase
		end
	end
	assign avs_waitrequest = (avs_read || avs_write) && (bus_reg != LQM_BUS_ACK);
	assign avs_readdata = rdata_reg;

	// Control register: bits 15..10 writable, warnings sticky; a new event beats the read clear
	logic [15:0] ctrl_next;
	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_hi && sel_ctrl) begin
			ctrl_next[15:10] = avs_writedata[15:10];
		end
		if (rd_ctrl) begin
			ctrl_next[LQM_BIT_FC_HI:0] = 10'h000;
		end
		ctrl_next[LQM_BIT_FC_HI:0] = ctrl_next[LQM_BIT_FC_HI:0] | warn_set;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_reg <= LQM_RST_CTRL;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Threshold access: trigger loads the selected threshold and never stores
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			thr_acc_reg <= 16'h0000;
			thr_hi_reg <= {LQM_NPARAM{LQM_RST_THR_HI}};
			thr_lo_reg <= {LQM_NPARAM{LQM_RST_THR_LO}};
			sd_opt_reg <= 1'b0;
		end else begin
			if (sel_thr && wr_hi) begin
				thr_acc_reg[11:8] <= avs_writedata[11:8];
			end
			if (sel_thr && wr_lo && wr_hi && wr_data && avs_writedata[LQM_BIT_THR_WR]
				&& (avs_writedata[11:9] < 3'(LQM_NPARAM))) begin
				if (avs_writedata[LQM_BIT_HLSEL]) begin
					thr_hi_reg[avs_writedata[11:9]] <= thr_wdata;
				end else begin
					thr_lo_reg[avs_writedata[11:9]] <= thr_wdata;
				end
			end
			if (sel_pcs && wr_hi) begin
				sd_opt_reg <= avs_writedata[LQM_BIT_SD_OPT];
			end
		end
	end

	// Interrupt: sticky status, violation bit one-shot until re-armed by the control read
	logic [1:0] irq_ev;
	assign irq_ev = {restart_hit, any_viol && armed_reg};
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_stat_reg <= LQM_RST_IRQ;
			irq_mask_reg <= LQM_RST_IRQ;
			armed_reg <= 1'b1;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~((sel_stat && wr_lo) ? avs_writedata[1:0] : 2'h0))
				| irq_ev;
			if (sel_mask && wr_lo) begin
				irq_mask_reg <= avs_writedata[1:0];
			end
			if (any_viol) begin
				armed_reg <= 1'b0;
			end else if (rd_ctrl) begin
				armed_reg <= 1'b1;
			end
		end
	end
	assign irq = |(irq_stat_reg & irq_mask_reg);

	// DSP restart pulse; link drop outlasts the pulse by one cycle so it is never missed
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rst_cnt_reg <= 3'h0;
			drop_reg <= 1'b0;
		end else begin
			if (restart_hit) begin
				rst_cnt_reg <= 3'(LQM_RESTART_CYC);
			end else if (rst_cnt_reg != 3'h0) begin
				rst_cnt_reg <= rst_cnt_reg - 3'h1;
			end
			if (restart_hit && !sd_opt_reg) begin
				drop_reg <= 1'b1;
			end else if (rst_cnt_reg == 3'h0) begin
				drop_reg <= 1'b0;
			end
		end
	end
	assign dsp_restart = (rst_cnt_reg != 3'h0);
	assign link_drop = drop_reg;

	// Checks
	a_restart_pulse: assert property (@(posedge clock) disable iff (rst)
		restart_hit |=> dsp_restart) else $error("restart not issued");
	a_drop_sdopt: assert property (@(posedge clock) disable iff (rst)
		restart_hit && !sd_opt_reg |=> link_drop) else $error("link not dropped");
	a_no_drop_opt: assert property (@(posedge clock) disable iff (rst)
		$rose(link_drop) |-> !$past(sd_opt_reg)) else $error("link dropped wrongly");
	a_idle_no_flag: assert property (@(posedge clock) disable iff (rst)
		!mon_active |-> warn_set == 10'h000) else $error("check while disabled");
	a_max_thr_off: assert property (@(posedge clock) disable iff (rst)
		thr_hi_reg[4] == LQM_THR_MAX |-> !hi_viol[4]) else $error("max threshold hit");
	a_flag_sticky: assert property (@(posedge clock) disable iff (rst)
		ctrl_reg[9] && !rd_ctrl |=> ctrl_reg[9]) else $error("flag lost");
	a_read_clear: assert property (@(posedge clock) disable iff (rst)
		rd_ctrl && warn_set == 10'h000 |=> ctrl_reg[9:0] == 10'h000) else $error("no clear");
	a_irq_level: assert property (@(posedge clock) disable iff (rst)
		any_viol && armed_reg && irq_mask_reg[0] |=> irq) else $error("irq missing");
	a_trig_zero: assert property (@(posedge clock) disable iff (rst)
		thr_acc_reg[LQM_BIT_THR_WR] == 1'b0) else $error("trigger stored");
	a_enable_gate: assert property (@(posedge clock) disable iff (rst)
		!ctrl_reg[LQM_BIT_ENABLE] |-> !restart_hit) else $error("restart while off");

	// Each enabled restart source starts a restart pulse of fixed length
	a_restart_fc: assert property (@(posedge clock) disable iff (rst)
		(hi_viol[4] || lo_viol[4]) && ctrl_reg[14] |=> dsp_restart)
		else $error("no restart on frequency control");
	a_restart_offset: assert property (@(posedge clock) disable iff (rst)
		(hi_viol[3] || lo_viol[3]) && ctrl_reg[13] |=> dsp_restart)
		else $error("no restart on frequency offset");
	a_restart_wander: assert property (@(posedge clock) disable iff (rst)
		(hi_viol[2] || lo_viol[2]) && ctrl_reg[12] |=> dsp_restart)
		else $error("no restart on baseline wander");
	a_restart_gain: assert property (@(posedge clock) disable iff (rst)
		(hi_viol[1] || lo_viol[1]) && ctrl_reg[11] |=> dsp_restart)
		else $error("no restart on digital gain");
	a_restart_coeff: assert property (@(posedge clock) disable iff (rst)
		(hi_viol[0] || lo_viol[0]) && ctrl_reg[10] |=> dsp_restart)
		else $error("no restart on equalizer coefficient");
	a_restart_cause: assert property (@(posedge clock) disable iff (rst)
		$rose(dsp_restart) |-> $past(restart_hit))
		else $error("restart without a cause");
	a_restart_len: assert property (@(posedge clock) disable iff (rst)
		restart_hit |=> dsp_restart [*4])
		else $error("restart pulse too short");
	a_restart_end: assert property (@(posedge clock) disable iff (rst)
		dsp_restart && (rst_cnt_reg == 3'h1) && !restart_hit |=> !dsp_restart)
		else $error("restart pulse too long");

	// Link drop follows the signal detect option and ends after the pulse
	a_drop_release: assert property (@(posedge clock) disable iff (rst)
		link_drop && !dsp_restart && !restart_hit |=> !link_drop)
		else $error("link drop stuck");
	a_drop_sd_off: assert property (@(posedge clock) disable iff (rst)
		restart_hit && sd_opt_reg && !link_drop |=> !link_drop)
		else $error("link dropped with option set");

	// Every violation lands in its own warning flag and stays there
	a_flag_fc_hi: assert property (@(posedge clock) disable iff (rst)
		hi_viol[4] |=> ctrl_reg[9])
		else $error("freq ctrl high flag missing");
	a_flag_fc_lo: assert property (@(posedge clock) disable iff (rst)
		lo_viol[4] |=> ctrl_reg[8])
		else $error("freq ctrl low flag missing");
	a_flag_offset_hi: assert property (@(posedge clock) disable iff (rst)
		hi_viol[3] |=> ctrl_reg[7])
		else $error("offset high flag missing");
	a_flag_offset_lo: assert property (@(posedge clock) disable iff (rst)
		lo_viol[3] |=> ctrl_reg[6])
		else $error("offset low flag missing");
	a_flag_wander_hi: assert property (@(posedge clock) disable iff (rst)
		hi_viol[2] |=> ctrl_reg[5])
		else $error("wander high flag missing");
	a_flag_wander_lo: assert property (@(posedge clock) disable iff (rst)
		lo_viol[2] |=> ctrl_reg[4])
		else $error("wander low flag missing");
	a_flag_gain_hi: assert property (@(posedge clock) disable iff (rst)
		hi_viol[1] |=> ctrl_reg[3])
		else $error("gain high flag missing");
	a_flag_gain_lo: assert property (@(posedge clock) disable iff (rst)
		lo_viol[1] |=> ctrl_reg[2])
		else $error("gain low flag missing");
	a_flag_coeff_hi: assert property (@(posedge clock) disable iff (rst)
		hi_viol[0] |=> ctrl_reg[1])
		else $error("coeff high flag missing");
	a_flag_coeff_lo: assert property (@(posedge clock) disable iff (rst)
		lo_viol[0] |=> ctrl_reg[0])
		else $error("coeff low flag missing");
	a_sticky_all: assert property (@(posedge clock) disable iff (rst)
		(warn_flags != 10'h000) && !rd_ctrl |=> (warn_flags & $past(warn_flags)) == $past(warn_flags))
		else $error("warning flag lost");
	a_no_sample_flag: assert property (@(posedge clock) disable iff (rst)
		!sample.valid |-> warn_set == 10'h000)
		else $error("flag without a sample");

	// Gating and disabled thresholds
	a_enable_flags: assert property (@(posedge clock) disable iff (rst)
		!ctrl_reg[LQM_BIT_ENABLE] |-> warn_set == 10'h000)
		else $error("flag while monitor off");
	a_link_gate: assert property (@(posedge clock) disable iff (rst)
		!link_ok |-> par_viol == 5'h00)
		else $error("violation without link");
	a_min_thr_off: assert property (@(posedge clock) disable iff (rst)
		thr_lo_reg[0] == LQM_THR_MIN |-> !lo_viol[0])
		else $error("min threshold hit");
	a_min_thr_fc: assert property (@(posedge clock) disable iff (rst)
		thr_lo_reg[4] == LQM_THR_MIN |-> !lo_viol[4])
		else $error("min freq ctrl threshold hit");
	a_max_thr_coeff: assert property (@(posedge clock) disable iff (rst)
		thr_hi_reg[0] == LQM_THR_MAX |-> !hi_viol[0])
		else $error("max coeff threshold hit");

	// Threshold access keeps the select and loads the chosen threshold
	a_sel_stored: assert property (@(posedge clock) disable iff (rst)
		sel_thr && wr_hi && (avs_writedata[11:8] == 4'h9) |=> (psel == 3'h4) && hl_sel)
		else $error("threshold select not kept");
	a_thr_load: assert property (@(posedge clock) disable iff (rst)
		sel_thr && wr_lo && wr_hi && wr_data && avs_writedata[LQM_BIT_THR_WR]
		&& (avs_writedata[11:8] == 4'h9) |=> thr_hi_reg[4] == $past(thr_wdata))
		else $error("threshold not loaded");

	// Interrupt masking and one-shot re-arm
	a_irq_off: assert property (@(posedge clock) disable iff (rst)
		irq_mask_reg == 2'h0 |-> !irq)
		else $error("irq while fully masked");
	a_irq_restart: assert property (@(posedge clock) disable iff (rst)
		restart_hit && irq_mask_reg[1] |=> irq)
		else $error("restart irq missing");
	a_irq_oneshot: assert property (@(posedge clock) disable iff (rst)
		any_viol && !armed_reg && !irq_stat_reg[0] |=> !irq_stat_reg[0])
		else $error("irq raised while disarmed");
	a_rearm_read: assert property (@(posedge clock) disable iff (rst)
		rd_ctrl && !any_viol |=> armed_reg)
		else $error("read did not re-arm");
endmodule

// ### shared/lqm_pkg.sv
// Purpose: Constants and types for the link quality threshold monitor
// Assumes: Avalon-MM word addressing, one 32-bit word per register
// Notes: Parameter index order follows the threshold access select encoding
package lqm_pkg;
	localparam int LQM_NPARAM = 5;
	localparam int LQM_VALW = 16;
	// Register word offsets (byte address = index * 4)
	localparam logic [4:0] LQM_IDX_MON_CTRL = 5'h1d;
	localparam logic [4:0] LQM_IDX_THR_ACC = 5'h1e;
	localparam logic [4:0] LQM_IDX_IRQ_STAT = 5'h10;
	localparam logic [4:0] LQM_IDX_IRQ_MASK = 5'h11;
	localparam logic [4:0] LQM_IDX_PCS_CFG = 5'h12;
	localparam logic [4:0] LQM_IDX_RX_STAT = 5'h13;
	// Monitor control fields
	localparam int LQM_BIT_ENABLE = 15;
	localparam int LQM_BIT_RST_FC = 14;
	localparam int LQM_BIT_RST_C1 = 10;
	localparam int LQM_BIT_FC_HI = 9;
	// Threshold access fields
	localparam int LQM_BIT_THR_WR = 12;
	localparam int LQM_POS_PSEL = 9;
	localparam int LQM_BIT_HLSEL = 8;
	// Coding sublayer config: signal detect option
	localparam int LQM_BIT_SD_OPT = 8;
	// Interrupt status / mask bits
	localparam int LQM_IRQ_VIOL = 0;
	localparam int LQM_IRQ_RESTART = 1;
	// Reset values
	localparam logic [15:0] LQM_RST_CTRL = 16'h0000;
	localparam logic [15:0] LQM_RST_THR_HI = 16'h7fff;
	localparam logic [15:0] LQM_RST_THR_LO = 16'h8000;
	localparam logic [15:0] LQM_THR_MAX = 16'h7fff;
	localparam logic [15:0] LQM_THR_MIN = 16'h8000;
	localparam logic [1:0] LQM_RST_IRQ = 2'h0;
	// Restart pulse width, in ns and in cycles of 25 ns
	localparam int LQM_CLK_NS = 25;
	localparam int LQM_RESTART_NS = 100;
	localparam int LQM_RESTART_CYC = (LQM_RESTART_NS + LQM_CLK_NS - 1) / LQM_CLK_NS;

	typedef enum logic [1:0] {
		LQM_BUS_IDLE,
		LQM_BUS_ACK
	} lqm_bus_e;

	// One sample of the receiver's adapted parameters
	typedef struct packed {
		logic valid;
		logic [LQM_NPARAM-1:0][LQM_VALW-1:0] value;
	} lqm_sample_s;
endpackage

// ### verif/lqm_monitor_tb.sv
// Purpose: Self-checking bench for the link quality threshold monitor
// Assumes: One wait cycle per bus access, parameter index 0 is C1
// Notes: Thresholds and flags are tracked by an integer model in the bench
`timescale 1ns/100ps
module lqm_monitor_tb;
	import lqm_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	lqm_sample_s sample = '0;
	logic link_up_100 = 1'b0;
	logic dsp_restart;
	logic link_drop;
	logic irq;
	int mismatches = 0;
	int checked = 0;
	int thr_hi[5] = '{5{32767}};
	int thr_lo[5] = '{5{-32768}};
	int flags = 0;
	int ctrl = 0;
	int link = 0;
	int n_rst;
	int n_drop;
	logic [31:0] q;
	int v;

	// Free-running core clock, 25 ns period
	always #12.5 clock = ~clock;

	lqm_monitor lqm_monitor_i (
		.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .sample(sample), .link_up_100(link_up_100),
		.dsp_restart(dsp_restart), .link_drop(link_drop), .irq(irq)
	);

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask

	// One Avalon access; request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int i;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		for (i = 0; i < 50; i++) begin
			@(posedge clock);
			if (avs_waitrequest === 1'b0)
				break;
		end
		if (i == 50) begin
			mismatches++;
			print_verdict();
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
	endtask

	// Load one threshold; model follows the same write
	task automatic set_thr(input int p, input int h, input int t);
		logic [15:0] tv;
		tv = t[15:0];
		bus(1'b1, LQM_IDX_THR_ACC, {tv, 3'b000, 1'b1, p[2:0], h[0], 8'h00});
		if (h == 1)
			thr_hi[p] = t;
		else
			thr_lo[p] = t;
	endtask

	// One sample pulse; counts restart and link drop cycles afterwards
	task automatic send(input int p, input int val);
		lqm_sample_s s;
		int k;
		s = '0;
		s.valid = 1'b1;
		s.value[p] = val[15:0];
		sample <= s;
		if (ctrl[15] && link == 1 && val > thr_hi[p])
			flags |= 1 << (2 * p + 1);
		if (ctrl[15] && link == 1 && val < thr_lo[p])
			flags |= 1 << (2 * p);
		@(posedge clock);
		sample.valid <= 1'b0;
		n_rst = 0;
		n_drop = 0;
		for (k = 0; k < 12; k++) begin
			@(posedge clock);
			n_rst += (dsp_restart === 1'b1);
			n_drop += (link_drop === 1'b1);
		end
	endtask

	// Control read returns the flags, then the model clears them
	task automatic rd_flags();
		bus(1'b0, LQM_IDX_MON_CTRL, 32'h0000_0000);
		chk("monitor control", (ctrl & 32'h0000_fc00) | flags, q);
		flags = 0;
	endtask

	initial begin
		void'($urandom(32'he39d830b));
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd_flags();
		bus(1'b0, 5'h05, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, q);
		bus(1'b1, LQM_IDX_IRQ_MASK, 32'h0000_0001);
		link_up_100 <= 1'b1;
		link = 1;
		ctrl = 32'h0000_8000;
		bus(1'b1, LQM_IDX_MON_CTRL, ctrl);
		// Extreme thresholds out of reset must never trip
		for (int p = 0; p < 5; p++) begin
			send(p, 32767);
			send(p, -32768);
		end
		rd_flags();
		chk("irq idle", 32'h0, {31'h0, irq});
		for (int p = 0; p < 5; p++) begin
			v = 1 + $urandom % 1000;
			set_thr(p, 1, v);
			set_thr(p, 0, -v);
		end
		bus(1'b0, LQM_IDX_THR_ACC, 32'h0000_0000);
		chk("write trigger", 32'h0, {31'h0, q[12]});
		chk("threshold select", 32'h8, {28'h0, q[11:8]});
		// Every flag: boundary value, violation, then a calm sample before the read
		for (int p = 0; p < 5; p++) begin
			for (int h = 0; h < 2; h++) begin
				send(p, h ? thr_hi[p] : thr_lo[p]);
				send(p, h ? thr_hi[p] + 1 : thr_lo[p] - 1);
				send(p, 0);
				chk("irq set", 32'h1, {31'h0, irq});
				rd_flags();
				rd_flags();
				bus(1'b1, LQM_IDX_IRQ_STAT, 32'h0000_0003);
				chk("irq clear", 32'h0, {31'h0, irq});
			end
		end
		// No link: checks are suppressed; then no enable
		link_up_100 <= 1'b0;
		link = 0;
		repeat (3) @(posedge clock); // Let the link synchroniser settle
		send(0, 2000);
		rd_flags();
		link_up_100 <= 1'b1;
		link = 1;
		ctrl = 0;
		bus(1'b1, LQM_IDX_MON_CTRL, ctrl);
		send(4, 2000);
		rd_flags();
		// Restart per parameter, with and without the signal detect option
		for (int sd = 0; sd < 2; sd++) begin
			bus(1'b1, LQM_IDX_PCS_CFG, sd << LQM_BIT_SD_OPT);
			for (int p = 0; p < 5; p++) begin
				ctrl = 32'h0000_8000 | (1 << (10 + p));
				bus(1'b1, LQM_IDX_MON_CTRL, ctrl);
				send((p + 1) % 5, 2000);
				chk("no restart", 32'h0, n_rst);
				rd_flags();
				send(p, -2000);
				chk("restart cycles", LQM_RESTART_CYC, n_rst);
				chk("link drop", {31'h0, sd == 0}, {31'h0, n_drop > 0});
				rd_flags();
				bus(1'b1, LQM_IDX_IRQ_STAT, 32'h0000_0003);
			end
		end
		print_verdict();
	end
endmodule
